// ===== src/dma_cmp_pkg.sv
// Constants shared by the channel completion and error logic.
// Assumes one 50 MHz core clock and a synchronous active-high reset.
package dma_cmp_pkg;
    // Channel status flag positions
    localparam int FLAG_ACTIVE = 0;
    localparam int FLAG_EOD    = 1;
    localparam int FLAG_EOC    = 2;
    localparam int FLAG_MABT   = 3;
    localparam int FLAG_TABT   = 4;
    localparam int FLAG_PPAR   = 5;
    localparam int FLAG_LPAR   = 6;
    localparam int FLAG_LFLT   = 7;
    localparam int FLAG_W      = 8;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    // Bits of the error flag group
    localparam logic [7:0] ERR_MASK  = 8'hf8;
    // Descriptor control word: interrupt enable position
    localparam int DCW_IE_BIT = 4;
    // Channel control write values
    localparam logic [31:0] CCR_SUSPEND = 32'h0000_0000;
    localparam logic [31:0] CCR_RESUME  = 32'h0000_0001;
    // Null next descriptor pointer
    localparam logic [31:0] NDP_NULL = 32'h0000_0000;
    // Translation unit control: PCI error response enables
    localparam int TUC_SERR_BIT = 0;
    localparam int TUC_PERR_BIT = 1;
    // Bytes per 32-bit word
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
    // Channel states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RUN  = 5'h02,
        ST_WAIT = 5'h04,
        ST_SUSP = 5'h08,
        ST_HALT = 5'h10
    } chan_state_t;
endpackage : dma_cmp_pkg

// ===== src/dma_channel_completion_error_ctrl.sv
// Completion, error and interrupt control of one chained DMA channel,
// with the unaligned packing unit between source and destination.
// Assumes all inputs are produced by logic on clk_sys_in.
//
// Function
// - one interrupt output per channel
// - zero count sets end-of-descriptor or end-of-chain
// - errors set flag, interrupt regardless of enable
// - error ends current descriptor, clears active
// - error flushes queues, stops fetching, halts
// - PCI errors answered per translation unit bits
// - finish memory-write-invalidate line before halting
// - no self restart after error
// - never forward data with parity error
// - descriptor fetch fault flags error and halts
// - completion flags only without errors
// - several error flags may stand together
// - continue past end-of-descriptor without acknowledgement
// - pack and unpack unaligned 32-bit words
// - hold packed data, never re-read source
// - write zero suspends, write one resumes
// - descriptor bit four enables completion interrupt
`timescale 1ns/100ps
module dma_channel_completion_error_ctrl (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // Descriptor load from the chain fetcher
    input  wire logic        desc_load_in,
    input  wire logic [31:0] descriptor_control_word_in,
    input  wire logic [31:0] next_descriptor_pointer_in,
    input  wire logic [31:0] byte_count_in,
    input  wire logic [1:0]  align_shift_in,
    input  wire logic        desc_fetch_fault_in,
    // Channel control register writes
    input  wire logic        ctrl_write_in,
    input  wire logic [31:0] ctrl_wdata_in,
    input  wire logic [dma_cmp_pkg::FLAG_W-1:0] status_clear_in,
    input  wire logic [31:0] translation_unit_control_reg_in,
    // Bus error reports
    input  wire logic        pci_master_abort_in,
    input  wire logic        pci_target_abort_in,
    input  wire logic        pci_parity_err_in,
    input  wire logic        lb_parity_err_in,
    input  wire logic        lb_fault_in,
    input  wire logic        mwi_active_in,
    input  wire logic        line_end_in,
    // Source data
    input  wire logic        src_valid_in,
    input  wire logic [31:0] src_data_in,
    output logic             src_ready_out,
    // Destination data
    output logic             dst_valid_out,
    output logic [31:0]      dst_data_out,
    input  wire logic        dst_ready_in,
    // Status and control outputs
    output logic [dma_cmp_pkg::FLAG_W-1:0] channel_status_flags_out,
    output logic             channel_irq_out,
    output logic             fetch_next_out,
    output logic             queue_flush_out,
    output logic             pci_serr_out,
    output logic             pci_perr_out,
    output logic             halted_out
);
    import dma_cmp_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////
    chan_state_t state;              // Present channel state
    chan_state_t susp_ret;           // State to return to on resume
    logic [7:0]  flags;              // Channel status flags
    logic [7:0]  err_now;            // Error events this cycle
    logic        any_err;            // Any error this cycle
    logic        draining;           // Finishing a write-invalidate line
    logic        irq_ie;             // Latched descriptor interrupt enable
    logic        cmp_irq;            // Sticky completion interrupt
    logic [31:0] next_ptr;           // Latched next descriptor pointer
    logic [31:0] bytes_left;         // Remaining bytes of descriptor
    logic [1:0]  shift;              // Byte realignment amount
    logic [31:0] hold;               // Previous source word
    logic        primed;             // Hold word valid
    logic        moving;             // Data may flow
    logic        take;               // Source word accepted
    logic        out_acc;            // Destination word accepted
    logic        done;               // Last word of descriptor accepted
    logic [63:0] pair;               // Current and held words joined
    logic [31:0] next_packed;        // Realigned word

    ////////////////////////////////////////////////////////////////
    // Event decode
    ////////////////////////////////////////////////////////////////
    // Gather error events into flag positions
    always_comb begin
        err_now = 8'h00;
        err_now[FLAG_MABT] = pci_master_abort_in;
        err_now[FLAG_TABT] = pci_target_abort_in;
        err_now[FLAG_PPAR] = pci_parity_err_in;
        err_now[FLAG_LPAR] = lb_parity_err_in;
        // Fault while fetching a descriptor reports as local fault
        err_now[FLAG_LFLT] = lb_fault_in | (desc_fetch_fault_in & (state == ST_WAIT));
    end

    assign any_err = |err_now;

    // Data moves while running or finishing a line
    assign moving  = (state == ST_RUN) | draining;
    assign src_ready_out = moving & (~dst_valid_out | dst_ready_in);
    // A word that arrives with a parity error is not taken
    assign take    = src_valid_in & src_ready_out & ~pci_parity_err_in
                     & ~lb_parity_err_in;
    assign out_acc = dst_valid_out & dst_ready_in;
    // Completion only in a clean run, never beside an error
    assign done    = out_acc & (bytes_left <= WORD_BYTES) & (state == ST_RUN)
                     & ~draining & ~any_err & ~|(flags & ERR_MASK);

    ////////////////////////////////////////////////////////////////
    // Channel state machine
    ////////////////////////////////////////////////////////////////
    // Run, wait for next descriptor, suspend and halt
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state    <= ST_IDLE;
            susp_ret <= ST_IDLE;
            draining <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (desc_load_in) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN, ST_WAIT: begin
                    if (any_err && !draining) begin
                        // Write-invalidate line completes first
                        if (mwi_active_in && !line_end_in) begin
                            draining <= 1'b1;
                        end else begin
                            state <= ST_HALT;
                        end
                    end else if (draining) begin
                        if (line_end_in) begin
                            draining <= 1'b0;
                            state    <= ST_HALT;
                        end
                    end else if (ctrl_write_in && ctrl_wdata_in == CCR_SUSPEND) begin
                        susp_ret <= state;
                        state    <= ST_SUSP;
                    end else if (done) begin
                        // Null pointer ends the chain
                        state <= (next_ptr == NDP_NULL) ? ST_IDLE : ST_WAIT;
                    end else if (state == ST_WAIT && desc_load_in) begin
                        state <= ST_RUN;
                    end
                end
                ST_SUSP: begin
                    if (any_err) begin
                        state <= ST_HALT;
                    end else if (ctrl_write_in && ctrl_wdata_in == CCR_RESUME) begin
                        state <= susp_ret;
                    end
                end
                ST_HALT: begin
                    // Leaves only when software loads a new descriptor
                    if (desc_load_in) begin
                        state <= ST_RUN;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Descriptor context
    ////////////////////////////////////////////////////////////////
    // Latch descriptor fields and count bytes down
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            next_ptr   <= NDP_NULL;
            bytes_left <= 32'h0000_0000;
            shift      <= 2'h0;
            irq_ie     <= 1'b0;
        end else if (desc_load_in && state != ST_SUSP && !draining) begin
            next_ptr   <= next_descriptor_pointer_in;
            bytes_left <= byte_count_in;
            shift      <= align_shift_in;
            irq_ie     <= descriptor_control_word_in[DCW_IE_BIT];
        end else if (out_acc) begin
            bytes_left <= (bytes_left > WORD_BYTES) ? bytes_left - WORD_BYTES
                                                    : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status flags
    ////////////////////////////////////////////////////////////////
    // Hardware sets win over software clears
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            flags <= FLAGS_RST;
        end else begin
            // Error flags accumulate, several may stand
            flags[7:3] <= (flags[7:3] & ~status_clear_in[7:3]) | err_now[7:3];
            // End of descriptor
            if (done && next_ptr != NDP_NULL) begin
                flags[FLAG_EOD] <= 1'b1;
            end else if (status_clear_in[FLAG_EOD]) begin
                flags[FLAG_EOD] <= 1'b0;
            end
            // End of chain
            if (done && next_ptr == NDP_NULL) begin
                flags[FLAG_EOC] <= 1'b1;
            end else if (status_clear_in[FLAG_EOC]) begin
                flags[FLAG_EOC] <= 1'b0;
            end
            // Active follows the state machine
            if (desc_load_in && (state == ST_IDLE || state == ST_HALT)) begin
                flags[FLAG_ACTIVE] <= 1'b1;
            end else if (any_err || (done && next_ptr == NDP_NULL)) begin
                flags[FLAG_ACTIVE] <= 1'b0;
            end
        end
    end

    // Completion interrupt stays until its flags are cleared
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cmp_irq <= 1'b0;
        end else if (done && irq_ie) begin
            cmp_irq <= 1'b1;
        end else if (status_clear_in[FLAG_EOD] || status_clear_in[FLAG_EOC]) begin
            cmp_irq <= 1'b0;
        end
    end

    // One interrupt line per channel
    assign channel_irq_out = cmp_irq | |(flags & ERR_MASK);
    assign channel_status_flags_out = flags;
    assign halted_out = (state == ST_HALT);

    ////////////////////////////////////////////////////////////////
    // Control pulses
    ////////////////////////////////////////////////////////////////
    // Next fetch request, queue flush and PCI error responses
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            fetch_next_out  <= 1'b0;
            queue_flush_out <= 1'b0;
            pci_serr_out    <= 1'b0;
            pci_perr_out    <= 1'b0;
        end else begin
            // No further fetch once an error is seen
            fetch_next_out  <= done & (next_ptr != NDP_NULL);
            // Flush at halt entry: at once, or at the line end when draining
            queue_flush_out <= (state != ST_HALT) & (state != ST_IDLE)
                               & ((any_err & ~draining & ~(mwi_active_in & ~line_end_in))
                               | (draining & line_end_in));
            pci_serr_out <= (pci_master_abort_in | pci_target_abort_in)
                            & translation_unit_control_reg_in[TUC_SERR_BIT];
            pci_perr_out <= pci_parity_err_in
                            & translation_unit_control_reg_in[TUC_PERR_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Packing unit
    ////////////////////////////////////////////////////////////////
    // Join held and new word and pick the realigned four bytes
    always_comb begin
        pair = {src_data_in, hold};
        next_packed = pair[31:0];
        case (shift)
            2'h0:    next_packed = src_data_in;
            2'h1:    next_packed = pair[39:8];
            2'h2:    next_packed = pair[47:16];
            2'h3:    next_packed = pair[55:24];
            default: next_packed = src_data_in;
        endcase
    end

    // Hold the previous word so the source is read once only
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            hold   <= 32'h0000_0000;
            primed <= 1'b0;
        end else if (desc_load_in || queue_flush_out) begin
            primed <= 1'b0;
        end else if (take) begin
            hold   <= src_data_in;
            primed <= 1'b1;
        end
    end

    // Destination register; unaligned first word only primes
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            dst_valid_out <= 1'b0;
            dst_data_out  <= 32'h0000_0000;
        end else if (queue_flush_out) begin
            dst_valid_out <= 1'b0;
        end else if (take && (primed || shift == 2'h0)) begin
            dst_valid_out <= 1'b1;
            dst_data_out  <= next_packed;
        end else if (out_acc) begin
            dst_valid_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////
    a_err_irq_now: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        any_err |=> channel_irq_out)
        else $error("error did not raise the interrupt");

    a_err_drops_active: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        any_err && !desc_load_in |=> !flags[FLAG_ACTIVE])
        else $error("active stayed set after error");

    a_no_eod_on_err: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        any_err |=> !$rose(flags[FLAG_EOD]) && !$rose(flags[FLAG_EOC]))
        else $error("completion flagged beside an error");

    a_eoc_clears_active: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        done && next_ptr == NDP_NULL && !desc_load_in
        |=> flags[FLAG_EOC] && !flags[FLAG_ACTIVE])
        else $error("end of chain did not settle");

    a_ie_off_quiet: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        done && !irq_ie && !cmp_irq |=> !cmp_irq)
        else $error("completion interrupt without enable");

    a_halt_holds: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        halted_out && !desc_load_in |=> halted_out)
        else $error("channel left halt on its own");

    a_parity_block: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (pci_parity_err_in || lb_parity_err_in) && !dst_valid_out |=> !dst_valid_out)
        else $error("word with parity error forwarded");

    a_no_fetch_err: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        halted_out |-> !fetch_next_out)
        else $error("descriptor fetch after error");

    a_flag_sticky: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        flags[FLAG_MABT] && !status_clear_in[FLAG_MABT] |=> flags[FLAG_MABT])
        else $error("error flag dropped without clear");

    // A word already in the output register may still drain while suspended
    a_susp_keeps: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        state == ST_SUSP && !any_err && !ctrl_write_in && !out_acc |=> state == ST_SUSP
        && $stable(bytes_left) && $stable(next_ptr))
        else $error("suspend did not preserve state");
endmodule : dma_channel_completion_error_ctrl

// ===== tb/bus_agent_model.sv
// Far-side model: a source memory agent that streams words and a
// destination agent that stalls on every other cycle.
// Assumes one clock shared with the channel and a synchronous reset.
`timescale 1ns/100ps
module bus_agent_model (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        src_ready_in,
    output logic             src_valid_out,
    output logic [31:0]      src_data_out,
    output logic             dst_ready_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Source: offers a word, holds it until taken, then offers the next
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            src_valid_out <= 1'b0;
            src_data_out  <= 32'h5a00_0000;
        end else begin
            src_valid_out <= 1'b1;
            // Advance only on an accepted word
            if (src_valid_out && src_ready_in) begin
                src_data_out <= src_data_out + 32'h0001_0203;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sink: ready alternates so the channel must hold its output
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            dst_ready_out <= 1'b0;
        end else begin
            dst_ready_out <= ~dst_ready_out;
        end
    end
endmodule : bus_agent_model

// ===== tb/dma_channel_completion_error_ctrl_tb.sv
// Self-checking bench for the channel completion and error control.
// Assumes the design package and the far-side model are compiled first.
`timescale 1ns/100ps
module dma_channel_completion_error_ctrl_tb;
    import dma_cmp_pkg::*;
    typedef struct { logic [4:0] err; logic [7:0] flags; logic serr; logic perr; } row_t;
    // Error pulses {lb fault, lb parity, pci parity, target, master}
    row_t rows [7] = '{'{5'h01, 8'h08, 1'b1, 1'b0}, '{5'h02, 8'h10, 1'b1, 1'b0},
                       '{5'h04, 8'h20, 1'b0, 1'b1}, '{5'h08, 8'h40, 1'b0, 1'b0},
                       '{5'h10, 8'h80, 1'b0, 1'b0}, '{5'h18, 8'hc0, 1'b0, 1'b0},
                       '{5'h05, 8'h28, 1'b1, 1'b1}};
    logic        clk_sys_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        desc_load = 1'b0, fetch_fault = 1'b0, ctrl_write = 1'b0;
    logic        mwi = 1'b0, line_end = 1'b0, src_valid, src_ready, dst_valid, dst_ready;
    logic [31:0] dcw = 32'h0, ndp = 32'h0, count = 32'h0, ctrl_wdata = 32'h0;
    logic [31:0] src_data, dst_data;
    logic [1:0]  shift = 2'h0;
    logic [7:0]  clr = 8'h00, flags;
    logic [4:0]  err = 5'h00;
    logic        irq, fetch_next, flush, serr, perr, halted, mon_on = 1'b0;
    logic [31:0] q [$];
    logic [31:0] held_word = 32'h0;   // Previous source word, for realignment
    logic        held_ok   = 1'b0;    // Previous source word is valid
    int          n_errors = 0, check_count = 0;

    always #10 clk_sys_in = ~clk_sys_in;

    bus_agent_model u_agent (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .src_ready_in(src_ready), .src_valid_out(src_valid), .src_data_out(src_data),
        .dst_ready_out(dst_ready));

    dma_channel_completion_error_ctrl u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .desc_load_in(desc_load), .descriptor_control_word_in(dcw),
        .next_descriptor_pointer_in(ndp), .byte_count_in(count), .align_shift_in(shift),
        .desc_fetch_fault_in(fetch_fault), .ctrl_write_in(ctrl_write),
        .ctrl_wdata_in(ctrl_wdata), .status_clear_in(clr),
        .translation_unit_control_reg_in(32'h0000_0003),
        .pci_master_abort_in(err[0]), .pci_target_abort_in(err[1]),
        .pci_parity_err_in(err[2]), .lb_parity_err_in(err[3]), .lb_fault_in(err[4]),
        .mwi_active_in(mwi), .line_end_in(line_end), .src_valid_in(src_valid),
        .src_data_in(src_data), .src_ready_out(src_ready), .dst_valid_out(dst_valid),
        .dst_data_out(dst_data), .dst_ready_in(dst_ready), .channel_status_flags_out(flags),
        .channel_irq_out(irq), .fetch_next_out(fetch_next), .queue_flush_out(flush),
        .pci_serr_out(serr), .pci_perr_out(perr), .halted_out(halted));

    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // Advance n edges, sampling settled outputs after the last one
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : step

    // Load one descriptor with a one-cycle strobe
    task automatic load(input logic ie, input logic [31:0] next, input logic [31:0] bytes);
        @(posedge clk_sys_in);
        desc_load <= 1'b1;
        dcw       <= 32'(ie) << DCW_IE_BIT;
        ndp       <= next;
        count     <= bytes;
        @(posedge clk_sys_in);
        desc_load <= 1'b0;
    endtask : load

    // Bounded wait for one status flag to rise
    task automatic wait_flag(input int idx);
        int i;
        for (i = 0; i < 400 && flags[idx] !== 1'b1; i++) step(1);
        if (i == 400) begin
            n_errors++;
            results();
        end
    endtask : wait_flag

    // Pulse the write-one-to-clear inputs for one cycle
    task automatic clear(input logic [7:0] bits);
        @(posedge clk_sys_in);
        clr <= bits;
        @(posedge clk_sys_in);
        clr <= 8'h00;
        #1;
    endtask : clear

    // One channel control write
    task automatic ctrl(input logic [31:0] value);
        @(posedge clk_sys_in);
        ctrl_write <= 1'b1;
        ctrl_wdata <= value;
        @(posedge clk_sys_in);
        ctrl_write <= 1'b0;
        #1;
    endtask : ctrl

    ////////////////////////////////////////////////////////////////////////////
    // Destination words must be the source words, in order, none dropped
    always @(posedge clk_sys_in) begin
        // Forget words of earlier scenarios
        if (!mon_on) begin
            q.delete();
            held_ok = 1'b0;
        end
        if (mon_on && dst_valid && dst_ready) begin
            check("dst_data", dst_data, (q.size() > 0) ? q.pop_front() : 32'hdead_0000);
        end
        if (mon_on && src_valid && src_ready) begin
            // Unaligned output takes its bytes from this word and the one before
            if (shift == 2'h0) begin
                q.push_back(src_data);
            end else if (held_ok) begin
                q.push_back(32'({src_data, held_word} >> (8 * shift)));
            end
            held_word = src_data;
            held_ok   = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        step(10);
        rst_in <= 1'b0;
        #1;
        check("reset flags", flags, FLAGS_RST);
        check("reset irq", irq, 1'b0);
        // Error table: every error raises its flag and halts, enable clear
        foreach (rows[r]) begin
            load(1'b0, 32'h0000_1000, 32'h0000_0040);
            step(3);
            err <= rows[r].err;
            step(1);
            err <= 5'h00;
            check("err flags", flags, rows[r].flags);
            check("err irq", irq, 1'b1);
            check("err halted", halted, 1'b1);
            check("err flush", flush, 1'b1);
            check("serr", serr, rows[r].serr);
            check("perr", perr, rows[r].perr);
            step(5);
            check("no restart", {flags, fetch_next}, {rows[r].flags, 1'b0});
            clear(ERR_MASK);
            check("err cleared irq", irq, 1'b0);
        end
        // Descriptor end with next pointer, then end of chain without enable
        mon_on = 1'b1;
        load(1'b1, 32'h0000_2000, 32'h0000_0008);
        wait_flag(FLAG_EOD);
        check("eod flags", {flags, fetch_next, irq}, 10'h00f);
        load(1'b0, NDP_NULL, 32'h0000_0004);
        wait_flag(FLAG_EOC);
        check("eoc flags", flags, 8'h06);
        clear(8'h02);
        check("eoc no irq", irq, 1'b0);
        clear(8'h04);
        // Suspend keeps state; value two ignored; resume finishes the chain
        load(1'b1, NDP_NULL, 32'h0000_0010);
        step(2);
        ctrl(CCR_SUSPEND);
        check("suspend", {src_ready, flags}, 9'h001);
        ctrl(32'h0000_0002);
        step(5);
        check("still suspended", {src_ready, flags}, 9'h001);
        ctrl(CCR_RESUME);
        check("resumed active", flags, 8'h01);
        wait_flag(FLAG_EOC);
        check("resumed eoc", {flags, irq}, 9'h009);
        clear(8'h04);
        mon_on = 1'b0;
        // Fault while fetching the next descriptor
        load(1'b0, 32'h0000_3000, 32'h0000_0004);
        wait_flag(FLAG_EOD);
        check("eod no ie", {flags, irq}, 9'h006);
        fetch_fault <= 1'b1;
        step(1);
        fetch_fault <= 1'b0;
        check("fetch fault", {flags, halted, irq}, 10'h20b);
        clear(8'hfe);
        // Abort during write-and-invalidate waits for the line end
        load(1'b0, 32'h0000_4000, 32'h0000_0040);
        mwi <= 1'b1;
        step(3);
        err <= 5'h02;
        step(1);
        err <= 5'h00;
        step(2);
        check("mwi pending", {flags, halted}, 9'h020);
        line_end <= 1'b1;
        step(1);
        line_end <= 1'b0;
        mwi <= 1'b0;
        check("mwi halted", {halted, flush}, 2'b11);
        // Unaligned chain end: one byte realignment, two output words
        clear(8'hfe);
        shift  <= 2'h1;
        mon_on = 1'b1;
        load(1'b0, NDP_NULL, 32'h0000_0008);
        wait_flag(FLAG_EOC);
        check("unaligned eoc", {flags, irq}, 9'h008);
        mon_on = 1'b0;
        results();
    end
endmodule : dma_channel_completion_error_ctrl_tb
